// *** shared/asc_regs.vh ***
// register map, field positions, reset values and counts of the converter control block
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
// register select codes
`define ASC_RS_STATUS     4'h0
`define ASC_RS_CTRL_MAIN  4'h1
`define ASC_RS_GPIO       4'h2
`define ASC_RS_GAIN_CAL   4'h3
`define ASC_RS_RESULT     4'h4
`define ASC_RS_SYS_OFS    4'h5
`define ASC_RS_SYS_GAIN   4'h6
`define ASC_RS_SELF_OFS   4'h7
`define ASC_RS_SELF_GAIN  4'h8
// command byte fields
`define ASC_CMD_START     7
`define ASC_CMD_MODE      6
`define ASC_CMD_CAL1      5
`define ASC_CMD_CAL0      4
`define ASC_CMD_PDOWN     3
`define ASC_CMD_RW        0
// status bit positions
`define ASC_ST_CALOVR     7
`define ASC_ST_OVR        3
`define ASC_ST_UNR        2
`define ASC_ST_BUSY       1
`define ASC_ST_READY      0
// main control bit positions
`define ASC_CM_LINE_FREQ_SELECT      7
`define ASC_CM_UNIPOLAR   6
`define ASC_CM_CLOCK_SOURCE_SELECT     5
`define ASC_CM_REF_BUFFER_ENABLE     4
`define ASC_CM_SIGNAL_BUFFER_ENABLE     3
`define ASC_CM_FORMAT     2
`define ASC_CM_SINGLE_CYCLE_SELECT     1
// reset values and write masks
`define ASC_CTRL_MAIN_RST 8'h02
`define ASC_GPIO_RST      8'h0F
`define ASC_GAIN_CAL_RST  8'h1E
`define ASC_CTRL_MASK     8'hFE
// calibration kinds
`define ASC_CAL_SELF      2'h1
`define ASC_CAL_SYS_OFS   2'h2
`define ASC_CAL_SYS_GAIN  2'h3
// self gain ceiling, about 1.9999999
`define ASC_SELF_GAIN_MAX 24'hFFFFFF
// results dropped while the filter settles
`define ASC_SETTLE_COUNT  2'h3
// clipping limits on the raw 26-bit value
`define ASC_UNI_MAX       26'sh0FFFFFF
`define ASC_BIP_MAX       26'sh07FFFFF
`define ASC_BIP_MIN       26'sh3800000
`define ASC_CODE_MAX_UNI  24'hFFFFFF
`define ASC_CODE_MIN_UNI  24'h000000
`define ASC_CODE_MAX_BIP  24'h7FFFFF
`define ASC_CODE_MIN_BIP  24'h800000
`endif

// *** hdl/asc_status_ctrl.v ***
// status, control and serial register access of a delta-sigma converter
//
// Behaviour
// [RL1] gain calibration overrange sets flag, clamps self gain
// [RL2] status rate shows rate of held result; the code also loads it with the calibration rate at calibration end
// [RL3] overrange sets flag and clips to maximum
// [RL4] underrange sets flag and clips to minimum
// [RL5] busy flag follows conversion or calibration activity
// [RL6] ready flag set on new result
// [RL7] read then new start clears ready
// [RL8] read during running conversion clears ready at once
// [RL9] line frequency bit picks 50Hz or 60Hz rates
// [RL10] polarity bit picks unipolar or bipolar range
// [RL11] clock source bit picks external or internal clock
// [RL12] reference buffer bit powers reference buffers
// [RL13] signal buffer bit powers input buffers
// [RL14] format bit picks bipolar code style
// [RL15] single cycle converts once then powers down
// [RL16] continuous mode drops first three results
// [RL17] ready pin rises at each conversion end; the pin carries the ready flag and stays high if the last result is unread
// [RL18] host reads synchronised to ready rise; the block does not tie reads to the ready rise
// [RL19] mode one command byte is register access
// [RL20] result shifts out msb first on falling edges
// [RL21] gpio direction selects input read or drive
// [RL22] calibration disable bits drop their coefficients
// [RL23] writes to read-only registers are ignored
`include "asc_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module asc_status_ctrl (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        spi_sclk,
    input  wire        spi_cs_n,
    input  wire        spi_din,
    output reg         spi_dout,
    output reg         spi_dout_oe_n,
    input  wire [3:0]  gpio_in,
    output reg  [3:0]  gpio_out,
    output reg  [3:0]  gpio_oe_n,
    output reg         conv_start,
    output reg  [2:0]  conv_rate,
    output reg         cal_start,
    output reg  [1:0]  cal_kind,
    output reg         mod_power_down,
    output reg         modulator_busy_flag,
    input  wire        mod_done,
    input  wire [25:0] mod_raw,
    input  wire        cal_done,
    input  wire        cal_gain_over,
    input  wire [23:0] cal_coef,
    output wire        line_freq_select,
    output wire        unipolar_select,
    output wire        clock_source_select,
    output wire        ref_buffer_enable,
    output wire        signal_buffer_enable,
    output wire        twos_off_format,
    output wire        single_cycle_select,
    output wire [2:0]  digital_gain_field,
    output wire        sys_gain_disable,
    output wire        sys_offset_disable,
    output wire        self_gain_disable,
    output wire        self_offset_disable
);

    // serial state codes, one-hot
    localparam [3:0] ST_IDLE  = 4'h1;
    localparam [3:0] ST_CMD   = 4'h2;
    localparam [3:0] ST_WDATA = 4'h4;
    localparam [3:0] ST_RDATA = 4'h8;

    // pin synchroniser stages: gpio, din, cs_n, sclk
    reg  [6:0]  sync1_reg;
    reg  [6:0]  sync2_reg;
    reg  [6:0]  sync3_reg;
    reg  [6:0]  filt_reg;
    wire [6:0]  filt_next;
    reg         sclk_old_reg;
    reg         cs_old_reg;

    // registers of the map
    reg  [7:0]  ctrl_main_reg;
    reg  [7:0]  gpio_ctrl_reg;
    reg  [7:0]  gain_cal_reg;
    reg  [23:0] result_reg;
    reg  [23:0] sys_ofs_reg;
    reg  [23:0] sys_gain_reg;
    reg  [23:0] self_ofs_reg;
    reg  [23:0] self_gain_reg;
    reg         cal_ovr_reg;
    reg  [2:0]  rate_reg;
    reg         over_range_flag;
    reg         under_range_flag;
    reg         result_ready_reg;
    reg         read_pending_reg;

    // conversion sequencing
    reg  [2:0]  active_rate_reg;
    reg  [1:0]  settle_reg;
    reg         calib_reg;
    reg  [1:0]  active_kind_reg;

    // serial engine
    reg  [3:0]  state_reg;
    reg  [4:0]  bit_cnt_reg;
    reg  [4:0]  bit_len_reg;
    reg  [23:0] shift_in_reg;
    reg  [23:0] shift_out_reg;
    reg  [3:0]  sel_reg;
    reg         cmd_go_reg;
    reg  [7:0]  cmd_byte_reg;
    reg         wr_go_reg;
    reg  [23:0] wr_data_reg;
    reg         result_read_reg;

    // decoded pin events
    wire        sclk_f;
    wire        cs_n_f;
    wire        din_f;
    wire [3:0]  gpio_f;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        cs_fall;
    wire [7:0]  next_byte;

    // read data and result shaping
    reg  [23:0] read_value;
    reg  [23:0] clipped;
    reg         raw_over;
    reg         raw_under;
    wire [7:0]  status_value;
    wire [7:0]  gpio_value;

    assign sclk_f    = filt_reg[0];
    assign cs_n_f    = filt_reg[1];
    assign din_f     = filt_reg[2];
    assign gpio_f    = filt_reg[6:3];
    assign sclk_rise = sclk_f & ~sclk_old_reg;
    assign sclk_fall = ~sclk_f & sclk_old_reg;
    assign cs_fall   = ~cs_n_f & cs_old_reg;
    assign next_byte = {shift_in_reg[6:0], din_f};

    // a bit changes only once stages two and three agree
    assign filt_next = ((sync2_reg ~^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & filt_reg);

    // control fields straight from their registers
    assign line_freq_select     = ctrl_main_reg[`ASC_CM_LINE_FREQ_SELECT];    // [RL9]
    assign unipolar_select      = ctrl_main_reg[`ASC_CM_UNIPOLAR]; // [RL10]
    assign clock_source_select  = ctrl_main_reg[`ASC_CM_CLOCK_SOURCE_SELECT];   // [RL11]
    assign ref_buffer_enable    = ctrl_main_reg[`ASC_CM_REF_BUFFER_ENABLE];   // [RL12]
    assign signal_buffer_enable = ctrl_main_reg[`ASC_CM_SIGNAL_BUFFER_ENABLE];   // [RL13]
    assign twos_off_format      = ctrl_main_reg[`ASC_CM_FORMAT];
    assign single_cycle_select  = ctrl_main_reg[`ASC_CM_SINGLE_CYCLE_SELECT];
    assign digital_gain_field   = gain_cal_reg[7:5];
    assign sys_gain_disable     = gain_cal_reg[4];                 // [RL22]
    assign sys_offset_disable   = gain_cal_reg[3];                 // [RL22]
    assign self_gain_disable    = gain_cal_reg[2];                 // [RL22]
    assign self_offset_disable  = gain_cal_reg[1];                 // [RL22]

    // status byte as software sees it
    assign status_value = {cal_ovr_reg, rate_reg, over_range_flag, under_range_flag,
                           modulator_busy_flag, result_ready_reg};
    // input pins read back where direction is input
    assign gpio_value = {gpio_ctrl_reg[7:4],
                         (gpio_ctrl_reg[7:4] & gpio_ctrl_reg[3:0]) | (~gpio_ctrl_reg[7:4] & gpio_f)}; // [RL21]

    // pin synchronisers
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_reg    <= 7'h02;
            sync2_reg    <= 7'h02;
            sync3_reg    <= 7'h02;
            filt_reg     <= 7'h02;
            sclk_old_reg <= 1'b0;
            cs_old_reg   <= 1'b1;
        end else begin
            sync1_reg    <= {gpio_in, spi_din, spi_cs_n, spi_sclk};
            sync2_reg    <= sync1_reg;
            sync3_reg    <= sync2_reg;
            filt_reg     <= filt_next;
            sclk_old_reg <= filt_reg[0];
            cs_old_reg   <= filt_reg[1];
        end
    end

    // read multiplexer, left aligned for the shifter
    always @* begin
        case (next_byte[4:1])
            `ASC_RS_STATUS:    read_value = {status_value, 16'h0000};
            `ASC_RS_CTRL_MAIN: read_value = {ctrl_main_reg, 16'h0000};
            `ASC_RS_GPIO:      read_value = {gpio_value, 16'h0000};
            `ASC_RS_GAIN_CAL:  read_value = {gain_cal_reg, 16'h0000};
            `ASC_RS_RESULT:    read_value = result_reg;
            `ASC_RS_SYS_OFS:   read_value = sys_ofs_reg;
            `ASC_RS_SYS_GAIN:  read_value = sys_gain_reg;
            `ASC_RS_SELF_OFS:  read_value = self_ofs_reg;
            `ASC_RS_SELF_GAIN: read_value = self_gain_reg;
            default:           read_value = 24'h000000;
        endcase
    end

    // clip the raw value and apply the output code style
    always @* begin
        if (ctrl_main_reg[`ASC_CM_UNIPOLAR]) begin
            raw_over  = ($signed(mod_raw) > `ASC_UNI_MAX);       // [RL3]
            raw_under = mod_raw[25];                             // [RL4]
            if (raw_over)
                clipped = `ASC_CODE_MAX_UNI;
            else if (raw_under)
                clipped = `ASC_CODE_MIN_UNI;
            else
                clipped = mod_raw[23:0];
        end else begin
            raw_over  = ($signed(mod_raw) > `ASC_BIP_MAX);       // [RL3]
            raw_under = ($signed(mod_raw) < `ASC_BIP_MIN);       // [RL4]
            if (raw_over)
                clipped = `ASC_CODE_MAX_BIP;
            else if (raw_under)
                clipped = `ASC_CODE_MIN_BIP;
            else
                clipped = mod_raw[23:0];
            // offset binary is two's complement with the sign flipped
            if (ctrl_main_reg[`ASC_CM_FORMAT])
                clipped = {~clipped[23], clipped[22:0]};         // [RL14]
        end
    end

    // serial engine: command byte, register write and read shifting
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg       <= ST_IDLE;
            bit_cnt_reg     <= 5'h00;
            bit_len_reg     <= 5'h00;
            shift_in_reg    <= 24'h000000;
            shift_out_reg   <= 24'h000000;
            sel_reg         <= 4'h0;
            cmd_go_reg      <= 1'b0;
            cmd_byte_reg    <= 8'h00;
            wr_go_reg       <= 1'b0;
            wr_data_reg     <= 24'h000000;
            result_read_reg <= 1'b0;
            spi_dout        <= 1'b0;
            spi_dout_oe_n   <= 1'b1;
        end else begin
            cmd_go_reg      <= 1'b0;
            wr_go_reg       <= 1'b0;
            result_read_reg <= 1'b0;
            spi_dout_oe_n   <= cs_n_f;
            // outside a read the pin carries the ready flag
            if (state_reg != ST_RDATA)
                spi_dout <= result_ready_reg;                    // [RL17]
            if (cs_n_f) begin
                // deselect aborts any transfer
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (cs_fall) begin
                            state_reg   <= ST_CMD;
                            bit_cnt_reg <= 5'h00;
                        end
                    end
                    ST_CMD: begin
                        if (sclk_rise) begin
                            shift_in_reg <= {shift_in_reg[22:0], din_f};
                            bit_cnt_reg  <= bit_cnt_reg + 5'h01;
                            if (bit_cnt_reg == 5'h07) begin
                                bit_cnt_reg <= 5'h00;
                                sel_reg     <= next_byte[4:1];
                                bit_len_reg <= (next_byte[4:1] >= `ASC_RS_RESULT) ? 5'h18 : 5'h08;
                                if (next_byte[`ASC_CMD_START] & next_byte[`ASC_CMD_MODE]) begin
                                    // register access
                                    if (next_byte[`ASC_CMD_RW]) begin                  // [RL19]
                                        state_reg     <= ST_RDATA;
                                        shift_out_reg <= read_value;
                                    end else begin
                                        state_reg <= ST_WDATA;
                                    end
                                end else if (next_byte[`ASC_CMD_START]) begin
                                    // conversion, calibration or power down
                                    cmd_go_reg   <= 1'b1;
                                    cmd_byte_reg <= next_byte;
                                end
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (sclk_rise) begin
                            shift_in_reg <= {shift_in_reg[22:0], din_f};
                            bit_cnt_reg  <= bit_cnt_reg + 5'h01;
                            if (bit_cnt_reg == bit_len_reg - 5'h01) begin
                                wr_go_reg   <= 1'b1;
                                wr_data_reg <= {shift_in_reg[22:0], din_f};
                                bit_cnt_reg <= 5'h00;
                                state_reg   <= ST_CMD;
                            end
                        end
                    end
                    ST_RDATA: begin
                        // msb first, changing on falling edges
                        if (sclk_fall) begin
                            spi_dout      <= shift_out_reg[23];             // [RL20]
                            shift_out_reg <= {shift_out_reg[22:0], 1'b0};
                        end
                        if (sclk_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 5'h01;
                            if (bit_cnt_reg == bit_len_reg - 5'h01) begin
                                result_read_reg <= (sel_reg == `ASC_RS_RESULT);
                                bit_cnt_reg     <= 5'h00;
                                state_reg       <= ST_CMD;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // register file, conversion sequencing and status flags
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_main_reg       <= `ASC_CTRL_MAIN_RST;
            gpio_ctrl_reg       <= `ASC_GPIO_RST;
            gain_cal_reg        <= `ASC_GAIN_CAL_RST;
            result_reg          <= 24'h000000;
            sys_ofs_reg         <= 24'h000000;
            sys_gain_reg        <= 24'h000000;
            self_ofs_reg        <= 24'h000000;
            self_gain_reg       <= 24'h000000;
            cal_ovr_reg         <= 1'b0;
            rate_reg            <= 3'h0;
            over_range_flag     <= 1'b0;
            under_range_flag    <= 1'b0;
            result_ready_reg    <= 1'b0;
            read_pending_reg    <= 1'b0;
            active_rate_reg     <= 3'h0;
            active_kind_reg     <= 2'h0;
            settle_reg          <= 2'h0;
            calib_reg           <= 1'b0;
            modulator_busy_flag <= 1'b0;
            mod_power_down      <= 1'b1;
            conv_start          <= 1'b0;
            conv_rate           <= 3'h0;
            cal_start           <= 1'b0;
            cal_kind            <= 2'h0;
            gpio_out            <= 4'hF;
            gpio_oe_n           <= 4'hF;
        end else begin
            conv_start <= 1'b0;
            cal_start  <= 1'b0;
            // gpio drivers follow direction and value bits
            gpio_out  <= gpio_ctrl_reg[3:0];                     // [RL21]
            gpio_oe_n <= ~gpio_ctrl_reg[7:4];                    // [RL21]
            // register writes; status and result have no write path
            if (wr_go_reg) begin
                case (sel_reg)                                   // [RL23]
                    `ASC_RS_CTRL_MAIN: ctrl_main_reg <= wr_data_reg[7:0] & `ASC_CTRL_MASK;
                    `ASC_RS_GPIO:      gpio_ctrl_reg <= wr_data_reg[7:0];
                    `ASC_RS_GAIN_CAL:  gain_cal_reg  <= wr_data_reg[7:0] & `ASC_CTRL_MASK;
                    `ASC_RS_SYS_OFS:   sys_ofs_reg   <= wr_data_reg;
                    `ASC_RS_SYS_GAIN:  sys_gain_reg  <= wr_data_reg;
                    `ASC_RS_SELF_OFS:  self_ofs_reg  <= wr_data_reg;
                    `ASC_RS_SELF_GAIN: self_gain_reg <= wr_data_reg;
                    default: begin
                    end
                endcase
            end
            // a finished result read clears ready now or at next start
            if (result_read_reg) begin
                if (modulator_busy_flag & ~calib_reg)
                    result_ready_reg <= 1'b0;                    // [RL8]
                else
                    read_pending_reg <= 1'b1;
            end
            // commands with mode bit clear
            if (cmd_go_reg) begin
                if (cmd_byte_reg[`ASC_CMD_PDOWN]) begin
                    modulator_busy_flag <= 1'b0;                 // [RL5]
                    mod_power_down      <= 1'b1;
                end else begin
                    modulator_busy_flag <= 1'b1;                 // [RL5]
                    mod_power_down      <= 1'b0;
                    active_rate_reg     <= cmd_byte_reg[2:0];
                    conv_rate           <= cmd_byte_reg[2:0];
                    active_kind_reg     <= cmd_byte_reg[5:4];
                    settle_reg          <= 2'h0;
                    if (cmd_byte_reg[5:4] != 2'h0) begin
                        calib_reg <= 1'b1;
                        cal_start <= 1'b1;
                        cal_kind  <= cmd_byte_reg[5:4];
                    end else begin
                        calib_reg  <= 1'b0;
                        conv_start <= 1'b1;
                    end
                    if (read_pending_reg) begin
                        result_ready_reg <= 1'b0;                // [RL7]
                        read_pending_reg <= 1'b0;
                    end
                end
            end
            // calibration completion loads the coefficient
            if (cal_done & modulator_busy_flag & calib_reg) begin
                modulator_busy_flag <= 1'b0;                     // [RL5]
                calib_reg           <= 1'b0;
                rate_reg            <= active_rate_reg;          // [RL2]
                case (active_kind_reg)
                    `ASC_CAL_SELF:    self_ofs_reg <= cal_coef;
                    `ASC_CAL_SYS_OFS: sys_ofs_reg  <= cal_coef;
                    `ASC_CAL_SYS_GAIN: begin
                        cal_ovr_reg  <= cal_gain_over;           // [RL1]
                        sys_gain_reg <= cal_coef;
                        if (cal_gain_over)
                            self_gain_reg <= `ASC_SELF_GAIN_MAX; // [RL1]
                    end
                    default: begin
                    end
                endcase
            end
            // conversion completion
            if (mod_done & modulator_busy_flag & ~calib_reg) begin
                if (~ctrl_main_reg[`ASC_CM_SINGLE_CYCLE_SELECT] & (settle_reg != `ASC_SETTLE_COUNT)) begin
                    // filter still settling, result dropped
                    settle_reg <= settle_reg + 2'h1;             // [RL16]
                end else begin
                    result_reg       <= clipped;                 // [RL3] [RL4]
                    over_range_flag  <= raw_over;                // [RL3]
                    under_range_flag <= raw_under;               // [RL4]
                    rate_reg         <= active_rate_reg;         // [RL2]
                    result_ready_reg <= 1'b1;                    // [RL6]
                    read_pending_reg <= 1'b0;
                    if (ctrl_main_reg[`ASC_CM_SINGLE_CYCLE_SELECT]) begin
                        modulator_busy_flag <= 1'b0;             // [RL15]
                        mod_power_down      <= 1'b1;             // [RL15]
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** dv/asc_props_properties.sv ***
// checker of start, busy, power-down and serial enable relations
`timescale 1ns/1ns
`default_nettype none
module asc_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic spi_dout_oe_n,
    input wire logic conv_start,
    input wire logic cal_start,
    input wire logic mod_done,
    input wire logic mod_power_down,
    input wire logic modulator_busy_flag,
    input wire logic single_cycle_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_busy; (conv_start || cal_start) |-> modulator_busy_flag; endproperty
    a_busy: assert property (p_busy) else $error("busy low at start");
    property p_cause; $rose(modulator_busy_flag) |-> (conv_start || cal_start); endproperty
    a_cause: assert property (p_cause) else $error("busy without start");
    property p_pulse; conv_start |=> !conv_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start not a pulse");
    property p_pd; $rose(mod_power_down) |-> ##[0:2] !modulator_busy_flag; endproperty
    a_pd: assert property (p_pd) else $error("busy in power down");
    property p_one; mod_done && modulator_busy_flag && single_cycle_select
        |-> ##[1:3] (mod_power_down && !modulator_busy_flag); endproperty
    a_one: assert property (p_one) else $error("single kept running");
    property p_cont; mod_done && modulator_busy_flag && !single_cycle_select |=> modulator_busy_flag; endproperty
    a_cont: assert property (p_cont) else $error("run stopped");
    property p_oe_off; spi_cs_n [*8] |-> spi_dout_oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("driven when deselected");
    property p_oe_on; !spi_cs_n [*8] |-> !spi_dout_oe_n; endproperty
    a_oe_on: assert property (p_oe_on) else $error("output idle while selected");
endmodule
`default_nettype wire

// *** dv/asc_host.sv ***
// serial host model: one frame is a command byte then data bits
`timescale 1ns/1ns
`default_nettype none
module asc_host (
    output logic     spi_sclk,
    output logic     spi_cs_n,
    output logic     spi_din,
    input wire logic spi_dout
);
    initial {spi_sclk, spi_cs_n, spi_din} = 3'b010;
    // clock stands low outside frames; bits change while it is low
    task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, input int n, output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd << (24 - n)};
        rd = 24'h0;
        spi_cs_n = 1'b0;
        #160;
        for (int i = 0; i < 8 + n; i++) begin
            spi_din = sh[31 - i];
            #80 spi_sclk = 1'b1;
            #78 if (i >= 8) rd = {rd[22:0], spi_dout};
            #2 spi_sclk = 1'b0;
        end
        #160 spi_cs_n = 1'b1;
        spi_din = ~spi_din;
        #160;
    endtask
endmodule
`default_nettype wire

// *** dv/asc_status_ctrl_test.sv ***
// self-checking bench of the converter status and control block
`timescale 1ns/1ns
`default_nettype none
module asc_status_ctrl_test;
    logic        clk = 1'b0, sys_rst = 1'b1, mod_done = 1'b0, cal_done = 1'b0, cal_gain_over = 1'b0;
    logic [3:0]  gpio_in = 4'h6;
    logic [25:0] mod_raw = 26'h0;
    logic [23:0] cal_coef = 24'h0, rd;
    wire         sclk, cs_n, din, dout, busy, pdown, lfs, cks, rbe, sbe, scs;
    wire  [3:0]  gpio_out, gpio_oe_n, dis;
    int          fail_count = 0, samples_checked = 0;
    asc_status_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_din(din),
        .spi_dout(dout), .spi_dout_oe_n(), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .conv_start(), .conv_rate(), .cal_start(), .cal_kind(), .mod_power_down(pdown),
        .modulator_busy_flag(busy), .mod_done(mod_done), .mod_raw(mod_raw), .cal_done(cal_done),
        .cal_gain_over(cal_gain_over), .cal_coef(cal_coef), .line_freq_select(lfs), .unipolar_select(),
        .clock_source_select(cks), .ref_buffer_enable(rbe), .signal_buffer_enable(sbe), .twos_off_format(),
        .single_cycle_select(scs), .digital_gain_field(), .sys_gain_disable(dis[3]),
        .sys_offset_disable(dis[2]), .self_gain_disable(dis[1]), .self_offset_disable(dis[0]));
    asc_host u_host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_din(din), .spi_dout(dout));
    initial forever #10 clk = ~clk;
    // value compare, reported at once
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] rs, input logic [23:0] d);
        u_host.frame({3'b110, rs, 1'b0}, d, rs > 4'h3 ? 24 : 8, rd);
    endtask
    task automatic rr(input logic [3:0] rs, input logic [23:0] exp);
        u_host.frame({3'b110, rs, 1'b1}, 24'h0, rs > 4'h3 ? 24 : 8, rd);
        chk(rd, exp);
    endtask
    task automatic cmd(input logic [7:0] c);
        u_host.frame(c, 24'h0, 0, rd);
    endtask
    // one modulator or calibration completion pulse
    task automatic done(input logic cal, input logic [25:0] raw);
        {mod_raw, mod_done, cal_done} = {raw, !cal, cal};
        @(posedge clk) #1 {mod_done, cal_done} = 2'b00;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_regs;
        rr(4'h1, 24'h02);
        rr(4'h2, 24'h06);
        rr(4'h3, 24'h1E);
        wr(4'h0, 24'hFF);
        wr(4'h4, 24'h123456);
        rr(4'h0, 24'h00);
        rr(4'h4, 24'h00);
        wr(4'h1, 24'hFF);
        rr(4'h1, 24'hFE);
        chk({lfs, cks, rbe, sbe}, 24'hF);
        wr(4'h3, 24'h14);
        chk(dis, 24'hA);
        wr(4'h2, 24'hA5);
        rr(4'h2, 24'hA4);
        chk({gpio_oe_n, gpio_out}, 24'h55);
        $display("register test done");
    endtask
    task automatic t_conv;
        wr(4'h1, 24'h00);
        chk({lfs, cks, rbe, sbe, scs}, 24'h0);
        cmd(8'h83);
        chk(busy, 24'h1);
        repeat (3) done(1'b0, 26'h0000123);
        rr(4'h0, 24'h02);
        chk(dout, 24'h0);
        done(1'b0, 26'h0000123);
        chk(dout, 24'h1);
        rr(4'h0, 24'h33);
        rr(4'h4, 24'h000123);
        rr(4'h0, 24'h32);
        done(1'b0, 26'h1000000);
        rr(4'h4, 24'h7FFFFF);
        rr(4'h0, 24'h3A);
        done(1'b0, 26'h3700000);
        rr(4'h0, 24'h37);
        wr(4'h1, 24'h04);
        done(1'b0, 26'h3700000);
        rr(4'h4, 24'h000000);
        cmd(8'h88);
        chk(busy, 24'h0);
        $display("continuous test done");
    endtask
    task automatic t_single;
        wr(4'h1, 24'h42);
        cmd(8'h80);
        done(1'b0, 26'h1000000);
        chk({busy, pdown}, 24'h1);
        rr(4'h0, 24'h09);
        rr(4'h4, 24'hFFFFFF);
        cmd(8'h80);
        rr(4'h0, 24'h0A);
        done(1'b0, 26'h0000005);
        cmd(8'h80);
        rr(4'h0, 24'h03);
        cmd(8'h88);
        for (int ov = 1; ov >= 0; ov--) begin
            cmd(8'hB0);
            cal_gain_over = ov[0];
            done(1'b1, 26'h0);
            rr(4'h0, {16'h0, ov[0], 7'h01});
        end
        rr(4'h8, 24'hFFFFFF);
        $display("single and calibration test done");
    endtask
    task automatic summarize;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        fail_count++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        t_regs();
        t_conv();
        t_single();
        summarize();
    end
endmodule
bind asc_status_ctrl asc_props u_props (.*);
`default_nettype wire
